// *** cmtc_regs.svh ***
// Register offsets, field positions and reset values of the capture/match timer.
`ifndef CMTC_REGS_SVH
`define CMTC_REGS_SVH
`define CMTC_OFF_CTRL 12'h000
`define CMTC_OFF_COUNT 12'h004
`define CMTC_OFF_PRESC 12'h008
`define CMTC_OFF_PCNT 12'h00C
`define CMTC_OFF_MCTRL 12'h010
`define CMTC_OFF_CCTRL 12'h014
`define CMTC_OFF_OUTS 12'h018
`define CMTC_OFF_IRQ_STAT 12'h01C
`define CMTC_OFF_IRQ_MASK 12'h020
`define CMTC_OFF_MATCH0 12'h040
`define CMTC_OFF_CAP0 12'h060
`define CMTC_CTRL_EN 0
`define CMTC_CTRL_CNTMODE 1
`define CMTC_CTRL_CRST 2
`define CMTC_CTRL_CEDGE 4
`define CMTC_CTRL_RESET 32'h0000_0000
`define CMTC_MATCH_RESET 32'h0000_0000
`define CMTC_SYNC_STAGES 2
`endif

// *** cmtc_pkg.sv ***
// Types shared by the capture/match timer files.
package cmtc_pkg;
  typedef enum logic [1:0] {CMTC_ACT_NONE, CMTC_ACT_LOW, CMTC_ACT_HIGH, CMTC_ACT_TOGGLE} cmtc_act_e;
  typedef enum logic [1:0] {CMTC_EDGE_OFF, CMTC_EDGE_RISE, CMTC_EDGE_FALL, CMTC_EDGE_BOTH} cmtc_edge_e;
  typedef logic [31:0] cmtc_word_t;
endpackage : cmtc_pkg

// *** cmtc_sync_edge.sv ***
// Two-stage synchroniser with rise and fall detection, one per input bit.
`timescale 1ns/10ps
`default_nettype none
module cmtc_sync_edge #(
  parameter int WIDTH = 5
) (
  input wire logic clk_i, // System clock.
  input wire logic rst_i, // Asynchronous reset, high.
  input wire logic [WIDTH-1:0] async_i, // Raw inputs.
  output logic [WIDTH-1:0] level_o, // Synchronised level.
  output logic [WIDTH-1:0] rise_o, // One-cycle rise pulse.
  output logic [WIDTH-1:0] fall_o // One-cycle fall pulse.
);
  import cmtc_pkg::*;
  logic [WIDTH-1:0] s1_q, s1_d; // First stage, read only by the second.
  logic [WIDTH-1:0] s2_q, s2_d; // Second stage.
  logic [WIDTH-1:0] s3_q, s3_d; // Delayed copy for edges.
  // Compute next stage values.
  always_comb begin
    s1_d = async_i;
    s2_d = s1_q;
    s3_d = s2_q;
  end
  // Register the stages.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end
  // Edges come from the settled stages only.
  assign level_o = s2_q;
  assign rise_o = s2_q & ~s3_q;
  assign fall_o = ~s2_q & s3_q;
endmodule : cmtc_sync_edge
`default_nettype wire

// *** cmtc_prescaler.sv ***
// Prescaler that issues one count tick each time it reaches its terminal value.
`timescale 1ns/10ps
`default_nettype none
module cmtc_prescaler #(
  parameter int WIDTH = 32
) (
  input wire logic clk_i, // System clock.
  input wire logic rst_i, // Asynchronous reset, high.
  input wire logic clr_i, // Restart from zero.
  input wire logic step_i, // One source event.
  input wire logic [WIDTH-1:0] term_i, // Terminal value.
  output logic [WIDTH-1:0] count_o, // Current prescale count.
  output logic tick_o // One-cycle count tick.
);
  import cmtc_pkg::*;
  logic [WIDTH-1:0] pc_q, pc_d; // Prescale counter.
  // Advance, wrap to zero at the terminal value.
  always_comb begin
    pc_d = pc_q;
    tick_o = 1'b0;
    if (clr_i) begin
      pc_d = '0;
    end else if (step_i) begin
      // R10 wrap and tick
      if (pc_q >= term_i) begin
        pc_d = '0;
        tick_o = 1'b1;
      end else begin
        pc_d = pc_q + 1'b1;
      end
    end
  end
  // Register the prescale count.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pc_q <= '0;
    end else begin
      pc_q <= pc_d;
    end
  end
  assign count_o = pc_q;
endmodule : cmtc_prescaler
`default_nettype wire

// *** cmtc_timer.sv ***
// Capture/match timer/counter top with its AXI4-Lite register slave.
// Contract
// R1 - Timer or external-clock counter mode selectable.
// R2 - 32-bit count gated by 32-bit prescaler.
// R3 - Four 32-bit match values compared to count.
// R4 - Continuous mode keeps counting, optional interrupt.
// R5 - Stop mode halts counter, optional interrupt.
// R6 - Reset mode zeroes counter, optional interrupt.
// R7 - Four captures latch count on input edge.
// R8 - Capture raises interrupt when enabled.
// R9 - Match output: low, high, toggle, none.
// R10 - Count advances at prescaler terminal, restarts.
// R11 - External inputs synchronised before edge detection.
`timescale 1ns/10ps
`default_nettype none
`include "cmtc_regs.svh"
module cmtc_timer #(
  parameter int N_MATCH = 4,
  parameter int N_CAP = 4
) (
  input wire logic CORE_CLK, // System clock, 125 MHz.
  input wire logic RESET, // Asynchronous reset, high.
  input wire logic [11:0] S_AXI_AWADDR, // Write address.
  input wire logic S_AXI_AWVALID, // Write address valid.
  output logic S_AXI_AWREADY, // Write address ready.
  input wire logic [31:0] S_AXI_WDATA, // Write data.
  input wire logic [3:0] S_AXI_WSTRB, // Write byte strobes.
  input wire logic S_AXI_WVALID, // Write data valid.
  output logic S_AXI_WREADY, // Write data ready.
  output logic [1:0] S_AXI_BRESP, // Write response.
  output logic S_AXI_BVALID, // Write response valid.
  input wire logic S_AXI_BREADY, // Write response ready.
  input wire logic [11:0] S_AXI_ARADDR, // Read address.
  input wire logic S_AXI_ARVALID, // Read address valid.
  output logic S_AXI_ARREADY, // Read address ready.
  output cmtc_pkg::cmtc_word_t S_AXI_RDATA, // Read data.
  output logic [1:0] S_AXI_RRESP, // Read response.
  output logic S_AXI_RVALID, // Read data valid.
  input wire logic S_AXI_RREADY, // Read data ready.
  input wire logic COUNT_CLK, // External count clock.
  input wire logic [N_CAP-1:0] CAP_IN, // Capture inputs.
  output logic [N_MATCH-1:0] MATCH_OUT, // Match output pins.
  output logic IRQ // Level interrupt.
);
  import cmtc_pkg::*;
  localparam int NI = N_MATCH + N_CAP; // Interrupt sources.
  // Refuse sizes the register map cannot hold.
  if (N_MATCH < 1 || N_MATCH > 4 || N_CAP < 1 || N_CAP > 4) begin : g_bad
    $error("cmtc_timer supports one to four match and capture channels.");
  end

  // Register state.
  logic [31:0] ctrl_q, ctrl_d; // Enable, mode, reset, capture edges.
  cmtc_word_t tc_q, tc_d; // Timer count.
  cmtc_word_t presc_q, presc_d; // Prescale terminal.
  logic [11:0] mctrl_q, mctrl_d; // Per match: irq, reset, stop.
  logic [7:0] cctrl_q, cctrl_d; // Per match output action.
  logic [NI-1:0] stat_q, stat_d; // Sticky interrupt flags.
  logic [NI-1:0] mask_q, mask_d; // Interrupt mask.
  logic [N_MATCH-1:0] mo_q, mo_d; // Match pin state.
  cmtc_word_t mr_q [N_MATCH]; // Match values.
  cmtc_word_t mr_d [N_MATCH];
  cmtc_word_t cr_q [N_CAP]; // Capture values.
  cmtc_word_t cr_d [N_CAP];
  // Bus state.
  logic aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
  logic [11:0] awa_q, awa_d;
  cmtc_word_t wd_q, wd_d, rd_q, rd_d;
  logic [3:0] ws_q, ws_d;
  logic [1:0] br_q, br_d, rr_q, rr_d;

  // Synchronised external inputs.
  logic [N_CAP:0] sy_lvl, sy_rise, sy_fall;
  cmtc_word_t pcount;
  logic tick, step, run;
  logic [N_MATCH-1:0] hit;
  logic [N_CAP-1:0] cap_ev;
  logic wr_go, rd_go;
  cmtc_word_t wmask;

  // R11 synchronise inputs
  cmtc_sync_edge #(.WIDTH(N_CAP + 1)) u_sync (
    .clk_i(CORE_CLK),
    .rst_i(RESET),
    .async_i({CAP_IN, COUNT_CLK}),
    .level_o(sy_lvl),
    .rise_o(sy_rise),
    .fall_o(sy_fall)
  );

  // R1 source select
  assign run = ctrl_q[`CMTC_CTRL_EN] & ~ctrl_q[`CMTC_CTRL_CRST];
  assign step = run & (ctrl_q[`CMTC_CTRL_CNTMODE] ? sy_rise[0] : 1'b1);

  // R2 prescaler gating
  cmtc_prescaler #(.WIDTH(32)) u_pre (
    .clk_i(CORE_CLK),
    .rst_i(RESET),
    .clr_i(ctrl_q[`CMTC_CTRL_CRST]),
    .step_i(step),
    .term_i(presc_q),
    .count_o(pcount),
    .tick_o(tick)
  );

  // Per channel match compare and capture edge select.
  for (genvar i = 0; i < N_MATCH; i++) begin : g_match
    // R3 match compare
    assign hit[i] = tick & (tc_q == mr_q[i]);
  end
  for (genvar i = 0; i < N_CAP; i++) begin : g_cap
    // R7 edge selection
    assign cap_ev[i] = (ctrl_q[`CMTC_CTRL_CEDGE + 2*i] & sy_rise[i+1]) |
                       (ctrl_q[`CMTC_CTRL_CEDGE + 2*i + 1] & sy_fall[i+1]);
  end

  // Bus handshakes; write fires once address and data are both held.
  assign S_AXI_AWREADY = ~aw_q & ~b_q;
  assign S_AXI_WREADY = ~w_q & ~b_q;
  assign S_AXI_ARREADY = ~r_q;
  assign wr_go = aw_q & w_q & ~b_q;
  assign rd_go = S_AXI_ARVALID & ~r_q;
  assign wmask = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};

  // Next state of the core and register file.
  always_comb begin
    logic ok;
    cmtc_word_t nv;
    ok = 1'b0;
    nv = '0;
    ctrl_d = ctrl_q;
    tc_d = tc_q;
    presc_d = presc_q;
    mctrl_d = mctrl_q;
    cctrl_d = cctrl_q;
    stat_d = stat_q;
    mask_d = mask_q;
    mo_d = mo_q;
    mr_d = mr_q;
    cr_d = cr_q;
    aw_d = aw_q | (S_AXI_AWVALID & S_AXI_AWREADY);
    w_d = w_q | (S_AXI_WVALID & S_AXI_WREADY);
    awa_d = (S_AXI_AWVALID & S_AXI_AWREADY) ? S_AXI_AWADDR : awa_q;
    wd_d = (S_AXI_WVALID & S_AXI_WREADY) ? S_AXI_WDATA : wd_q;
    ws_d = (S_AXI_WVALID & S_AXI_WREADY) ? S_AXI_WSTRB : ws_q;
    b_d = b_q & ~S_AXI_BREADY;
    br_d = br_q;
    r_d = r_q & ~S_AXI_RREADY;
    rd_d = rd_q;
    rr_d = rr_q;
    // Counter: hold in reset, else advance on tick.
    if (ctrl_q[`CMTC_CTRL_CRST]) begin
      tc_d = '0;
    end else if (tick) begin
      // R2 count on tick
      tc_d = tc_q + 32'h0000_0001;
    end
    // Match actions; reset wins over continue, and stop still clears the enable alongside it.
    for (int i = 0; i < N_MATCH; i++) begin
      if (hit[i]) begin
        // R4 optional match interrupt
        if (mctrl_q[3*i]) stat_d[i] = 1'b1;
        // R6 reset on match
        if (mctrl_q[3*i+1]) tc_d = '0;
        // R5 stop on match
        if (mctrl_q[3*i+2]) ctrl_d[`CMTC_CTRL_EN] = 1'b0;
        // R9 output action
        unique case (cmtc_act_e'(cctrl_q[2*i +: 2]))
          CMTC_ACT_LOW: mo_d[i] = 1'b0;
          CMTC_ACT_HIGH: mo_d[i] = 1'b1;
          CMTC_ACT_TOGGLE: mo_d[i] = ~mo_q[i];
          CMTC_ACT_NONE: mo_d[i] = mo_q[i];
        endcase
      end
    end
    // Register write.
    if (wr_go) begin
      ok = 1'b1;
      nv = (wd_q & wmask);
      unique case (awa_q)
        `CMTC_OFF_CTRL: ctrl_d = (ctrl_q & ~wmask) | nv;
        `CMTC_OFF_COUNT: tc_d = (tc_q & ~wmask) | nv;
        `CMTC_OFF_PRESC: presc_d = (presc_q & ~wmask) | nv;
        `CMTC_OFF_MCTRL: mctrl_d = 12'((mctrl_q & ~wmask[11:0]) | nv[11:0]);
        `CMTC_OFF_CCTRL: cctrl_d = (cctrl_q & ~wmask[7:0]) | nv[7:0];
        `CMTC_OFF_OUTS: mo_d = N_MATCH'((mo_q & ~wmask[N_MATCH-1:0]) | nv[N_MATCH-1:0]);
        `CMTC_OFF_IRQ_MASK: mask_d = NI'((mask_q & ~wmask[NI-1:0]) | nv[NI-1:0]);
        default: begin
          ok = 1'b0;
          for (int i = 0; i < N_MATCH; i++) begin
            if (awa_q == 12'(`CMTC_OFF_MATCH0 + 4*i)) begin
              mr_d[i] = (mr_q[i] & ~wmask) | nv;
              ok = 1'b1;
            end
          end
        end
      endcase
      aw_d = 1'b0;
      w_d = 1'b0;
      b_d = 1'b1;
      br_d = ok ? 2'b00 : 2'b10;
    end
    // Register read; reading the status clears it.
    if (rd_go) begin
      ok = 1'b1;
      rd_d = '0;
      unique case (S_AXI_ARADDR)
        `CMTC_OFF_CTRL: rd_d = ctrl_q;
        `CMTC_OFF_COUNT: rd_d = tc_q;
        `CMTC_OFF_PRESC: rd_d = presc_q;
        `CMTC_OFF_PCNT: rd_d = pcount;
        `CMTC_OFF_MCTRL: rd_d = 32'(mctrl_q);
        `CMTC_OFF_CCTRL: rd_d = 32'(cctrl_q);
        `CMTC_OFF_OUTS: rd_d = 32'(mo_q);
        `CMTC_OFF_IRQ_MASK: rd_d = 32'(mask_q);
        `CMTC_OFF_IRQ_STAT: begin
          rd_d = 32'(stat_q);
          stat_d = '0;
        end
        default: begin
          ok = 1'b0;
          for (int i = 0; i < N_MATCH; i++) begin
            if (S_AXI_ARADDR == 12'(`CMTC_OFF_MATCH0 + 4*i)) begin
              rd_d = mr_q[i];
              ok = 1'b1;
            end
          end
          for (int i = 0; i < N_CAP; i++) begin
            if (S_AXI_ARADDR == 12'(`CMTC_OFF_CAP0 + 4*i)) begin
              rd_d = cr_q[i];
              ok = 1'b1;
            end
          end
        end
      endcase
      r_d = 1'b1;
      rr_d = ok ? 2'b00 : 2'b10;
    end
    // Events set flags last, so a set beats a read clear.
    for (int i = 0; i < N_MATCH; i++) begin
      if (hit[i] && mctrl_q[3*i]) stat_d[i] = 1'b1;
    end
    for (int i = 0; i < N_CAP; i++) begin
      if (cap_ev[i]) begin
        // R7 latch count
        cr_d[i] = tc_q;
        // R8 capture interrupt
        if (ctrl_q[`CMTC_CTRL_CEDGE + 8 + i]) stat_d[N_MATCH + i] = 1'b1;
      end
    end
  end

  // Register all state.
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      ctrl_q <= `CMTC_CTRL_RESET;
      tc_q <= '0;
      presc_q <= '0;
      mctrl_q <= '0;
      cctrl_q <= '0;
      stat_q <= '0;
      mask_q <= '0;
      mo_q <= '0;
      for (int i = 0; i < N_MATCH; i++) mr_q[i] <= `CMTC_MATCH_RESET;
      for (int i = 0; i < N_CAP; i++) cr_q[i] <= '0;
      aw_q <= 1'b0;
      w_q <= 1'b0;
      b_q <= 1'b0;
      r_q <= 1'b0;
      awa_q <= '0;
      wd_q <= '0;
      ws_q <= '0;
      br_q <= '0;
      rd_q <= '0;
      rr_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      tc_q <= tc_d;
      presc_q <= presc_d;
      mctrl_q <= mctrl_d;
      cctrl_q <= cctrl_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      mo_q <= mo_d;
      mr_q <= mr_d;
      cr_q <= cr_d;
      aw_q <= aw_d;
      w_q <= w_d;
      b_q <= b_d;
      r_q <= r_d;
      awa_q <= awa_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      br_q <= br_d;
      rd_q <= rd_d;
      rr_q <= rr_d;
    end
  end

  // Drive outputs from registers.
  assign S_AXI_BVALID = b_q;
  assign S_AXI_BRESP = br_q;
  assign S_AXI_RVALID = r_q;
  assign S_AXI_RDATA = rd_q;
  assign S_AXI_RRESP = rr_q;
  assign MATCH_OUT = mo_q;
  assign IRQ = |(stat_q & mask_q);
endmodule : cmtc_timer
`default_nettype wire

// *** cmtc_checker.sv ***
// Bus handshake checks for the capture/match timer top.
`timescale 1ns/10ps
`default_nettype none
module cmtc_checker #(
  parameter int N_MATCH = 4, // Match channels.
  parameter int N_CAP = 4 // Capture channels.
) (
  input wire logic CORE_CLK, // Clock.
  input wire logic RESET, // Reset.
  input wire logic S_AXI_AWVALID, // AW valid.
  input wire logic S_AXI_AWREADY, // AW ready.
  input wire logic S_AXI_WVALID, // W valid.
  input wire logic S_AXI_WREADY, // W ready.
  input wire logic [1:0] S_AXI_BRESP, // B code.
  input wire logic S_AXI_BVALID, // B valid.
  input wire logic S_AXI_BREADY, // B ready.
  input wire logic S_AXI_ARVALID, // AR valid.
  input wire logic S_AXI_ARREADY, // AR ready.
  input wire cmtc_pkg::cmtc_word_t S_AXI_RDATA, // R data.
  input wire logic [1:0] S_AXI_RRESP, // R code.
  input wire logic S_AXI_RVALID, // R valid.
  input wire logic S_AXI_RREADY, // R ready.
  input wire logic [N_MATCH-1:0] MATCH_OUT, // Match pins.
  input wire logic IRQ // Interrupt.
);
  import cmtc_pkg::*;
  // Every check samples the system clock and rests in reset.
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RESET);
  // A write whose halves arrive together is answered two edges on.
  a_wr_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
    else $error("write not answered in time");
  a_b_holds: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write answer dropped early");
  a_b_release: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write answer repeated");
  a_b_blocks: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write taken while answer pending");
  a_rd_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read not answered in time");
  a_r_holds: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read answer changed early");
  a_r_release: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID && S_AXI_ARREADY)
    else $error("read answer not retired");
  a_err_zero: assert property (S_AXI_RVALID && S_AXI_RRESP == 2'h2 |-> S_AXI_RDATA == 32'h0000_0000)
    else $error("refused read returned data");
  // Main scenarios reached by the bench.
  c_err: cover property (S_AXI_BVALID && S_AXI_BRESP == 2'h2);
  c_irq: cover property ($rose(IRQ));
  c_pin: cover property ($changed(MATCH_OUT));
endmodule : cmtc_checker
bind cmtc_timer cmtc_checker #(.N_MATCH(N_MATCH), .N_CAP(N_CAP)) i_cmtc_checker (
  .CORE_CLK, .RESET, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP,
  .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
  .S_AXI_RVALID, .S_AXI_RREADY, .MATCH_OUT, .IRQ);
`default_nettype wire

// *** cmtc_far_side.sv ***
// Far-side model: external count clock and capture input drivers.
`timescale 1ns/10ps
`default_nettype none
module cmtc_far_side (
  input wire logic clk, // System clock.
  output logic count_clk, // External count clock.
  output logic [3:0] cap // Capture inputs.
);
  // The count clock and all four capture lines idle low until a task moves them.
  initial begin
    count_clk = 1'b0;
    cap = 4'h0;
  end
  // held past sync
  // Pulses keep each level for hold cycles, two at least, so sync sees them.
  task automatic pulses(input int n, input int hold);
    repeat (n) begin
      @(posedge clk);
      count_clk <= 1'b1;
      repeat (hold) @(posedge clk);
      count_clk <= 1'b0;
      repeat (hold - 1) @(posedge clk);
    end
    repeat (6) @(posedge clk);
  endtask : pulses
  // held past sync
  // One capture line moves, then the model waits for the latch.
  task automatic cap_set(input int j, input logic v);
    @(posedge clk);
    cap[j] <= v;
    repeat (6) @(posedge clk);
  endtask : cap_set
endmodule : cmtc_far_side
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the capture/match timer.
`timescale 1ns/10ps
`default_nettype none
`include "cmtc_regs.svh"
module tb_top;
  import cmtc_pkg::*;
  logic clk = 1'b0; // System clock.
  logic rst = 1'b1; // Reset, high.
  logic [11:0] awaddr = 12'h000, araddr = 12'h000; // Addresses.
  cmtc_word_t wdata = 32'h0000_0000; // Write data.
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0; // Requests.
  logic awready, wready, bvalid, arready, rvalid, irq, count_clk; // Answers and pins.
  logic [1:0] bresp, rresp; // Response codes.
  logic [3:0] cap, mout; // Capture and match pins.
  cmtc_word_t rdata; // Read data.
  int n_fail = 0, checks = 0; // Counters.
  // Free-running 125 MHz clock.
  always #4 clk = ~clk;
  cmtc_timer i_cmtc_timer (.CORE_CLK(clk), .RESET(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .COUNT_CLK(count_clk),
    .CAP_IN(cap), .MATCH_OUT(mout), .IRQ(irq));
  cmtc_far_side i_cmtc_far_side (.clk(clk), .count_clk(count_clk), .cap(cap));
  task automatic report_and_stop();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input cmtc_word_t got, input cmtc_word_t exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Ready is looked at on the falling edge; the next rising edge takes it.
  task automatic wr(input logic [11:0] a, input cmtc_word_t d, input logic [1:0] er = 2'h0);
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (tb !== 1'b1);
    bready <= 1'b0;
    chk(32'(r), 32'(er));
  endtask : wr
  task automatic rd(input logic [11:0] a, output cmtc_word_t d, output logic [1:0] r);
    logic ta, tv;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      ta = arvalid && arready;
      tv = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
    end while (tv !== 1'b1);
    rready <= 1'b0;
  endtask : rd
  task automatic rdc(input logic [11:0] a, input cmtc_word_t e, input logic [1:0] er = 2'h0);
    cmtc_word_t d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
    chk(32'(r), 32'(er));
  endtask : rdc
  // Reset values and the refused address.
  task automatic t_reset();
    rdc(`CMTC_OFF_CTRL, `CMTC_CTRL_RESET);
    rdc(`CMTC_OFF_MATCH0, `CMTC_MATCH_RESET);
    wr(12'h0FC, 32'hFFFF_FFFF, 2'h2);
    rdc(12'h0FC, 32'h0000_0000, 2'h2);
    chk(32'(irq), 32'h0000_0000);
  endtask : t_reset
  // Timer mode, divide by four, continuous match 2 passed on the way.
  task automatic t_prescale();
    cmtc_word_t d;
    wr(`CMTC_OFF_PRESC, 32'h0000_0003);
    wr(`CMTC_OFF_MATCH0 + 12'h008, 32'h0000_0005);
    wr(`CMTC_OFF_MCTRL, 32'h0000_0040);
    wr(`CMTC_OFF_IRQ_MASK, 32'h0000_0004);
    wr(`CMTC_OFF_CTRL, 32'h0000_0001);
    repeat (38) @(posedge clk);
    wr(`CMTC_OFF_CTRL, 32'h0000_0000);
    rdc(`CMTC_OFF_COUNT, 32'h0000_000A);
    rdc(`CMTC_OFF_PCNT, 32'h0000_0002);
    chk(32'(irq), 32'h0000_0001);
    rdc(`CMTC_OFF_IRQ_STAT, 32'h0000_0004);
    rdc(`CMTC_OFF_IRQ_STAT, 32'h0000_0000);
    chk(32'(irq), 32'h0000_0000);
    // Counter reset zeroes both the count and the prescale count.
    wr(`CMTC_OFF_CTRL, 32'h0000_0004);
    rdc(`CMTC_OFF_COUNT, 32'h0000_0000);
    rdc(`CMTC_OFF_PCNT, 32'h0000_0000);
  endtask : t_prescale
  // Counter mode counts only external rising edges, fast and slow.
  task automatic t_counter();
    wr(`CMTC_OFF_COUNT, 32'h0000_0000);
    wr(`CMTC_OFF_PRESC, 32'h0000_0000);
    wr(`CMTC_OFF_CTRL, 32'h0000_0003);
    i_cmtc_far_side.pulses(4, 2);
    i_cmtc_far_side.pulses(3, 5);
    wr(`CMTC_OFF_CTRL, 32'h0000_0000);
    rdc(`CMTC_OFF_COUNT, 32'h0000_0007);
    // Match 2 fires again as the count leaves five; reading clears it.
    rdc(`CMTC_OFF_IRQ_STAT, 32'h0000_0004);
  endtask : t_counter
  // Match 1 with reset keeps the count at or below four.
  task automatic t_rst_match();
    cmtc_word_t d;
    logic [1:0] r;
    wr(`CMTC_OFF_COUNT, 32'h0000_0000);
    wr(`CMTC_OFF_MATCH0 + 12'h004, 32'h0000_0004);
    wr(`CMTC_OFF_MCTRL, 32'h0000_0018);
    wr(`CMTC_OFF_CTRL, 32'h0000_0001);
    repeat (30) @(posedge clk);
    wr(`CMTC_OFF_CTRL, 32'h0000_0000);
    rd(`CMTC_OFF_COUNT, d, r);
    chk(32'(d <= 32'h0000_0004), 32'h0000_0001);
    rdc(`CMTC_OFF_IRQ_STAT, 32'h0000_0002);
  endtask : t_rst_match
  // Every pin action on a stopping match 0.
  task automatic t_actions();
    cmtc_word_t d;
    logic [1:0] r;
    wr(`CMTC_OFF_MATCH0, 32'h0000_0003);
    wr(`CMTC_OFF_MCTRL, 32'h0000_0005);
    for (int a = 0; a < 4; a++) begin
      wr(`CMTC_OFF_COUNT, 32'h0000_0000);
      wr(`CMTC_OFF_OUTS, 32'(a < 2));
      wr(`CMTC_OFF_CCTRL, 32'(a));
      wr(`CMTC_OFF_CTRL, 32'h0000_0001);
      repeat (20) @(posedge clk);
      chk(32'(mout[0]), 32'(a != 1));
      rdc(`CMTC_OFF_CTRL, 32'h0000_0000);
      rd(`CMTC_OFF_COUNT, d, r);
      chk(32'(d inside {32'h0000_0003, 32'h0000_0004}), 32'h0000_0001);
      rdc(`CMTC_OFF_IRQ_STAT, 32'h0000_0001);
    end
  endtask : t_actions
  // Captures on a frozen count; edge select, enable and mask.
  task automatic t_capture();
    wr(`CMTC_OFF_MCTRL, 32'h0000_0000);
    wr(`CMTC_OFF_PRESC, 32'hFFFF_FFFF);
    wr(`CMTC_OFF_COUNT, 32'h1234_5678);
    wr(`CMTC_OFF_IRQ_MASK, 32'h0000_000F);
    wr(`CMTC_OFF_CTRL, 32'h0000_4111);
    i_cmtc_far_side.cap_set(2, 1'b1);
    i_cmtc_far_side.cap_set(0, 1'b1);
    rdc(`CMTC_OFF_CAP0 + 12'h008, 32'h1234_5678);
    rdc(`CMTC_OFF_CAP0, 32'h1234_5678);
    chk(32'(irq), 32'h0000_0000);
    wr(`CMTC_OFF_IRQ_MASK, 32'h0000_0040);
    @(negedge clk);
    chk(32'(irq), 32'h0000_0001);
    wr(`CMTC_OFF_COUNT, 32'h0000_0ABC);
    i_cmtc_far_side.cap_set(2, 1'b0);
    rdc(`CMTC_OFF_CAP0 + 12'h008, 32'h1234_5678);
    rdc(`CMTC_OFF_IRQ_STAT, 32'h0000_0040);
    chk(32'(irq), 32'h0000_0000);
  endtask : t_capture
  // Main sequence after ten reset cycles.
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_prescale();
    t_counter();
    t_rst_match();
    t_actions();
    t_capture();
    report_and_stop();
  end
  // Watchdog well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
